// ===== swpc_consts.svh
// Notes on behaviour
// - switching clock is 16MHz over divisor 11..80
// - strap loads frequency; host write replaces it
// - frequency in kHz, 200 to 1330, global
// - frequency and gain are 16-bit linear-11 words
// - bits 7:4 group number, zero means 16
// - bits 3:0 position, zero means 16, 22.5 deg
// - sharing rails ignore interleave, use share link
// - interleave per page, default from strapped address
// - gain per page, milliohms, resets to AA66h
// - all three read/write and write protectable
`ifndef SWPC_CONSTS_SVH
`define SWPC_CONSTS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define SWPC_CMD_FREQ 8'h33
`define SWPC_CMD_INTER 8'h37
`define SWPC_CMD_GAIN 8'h38

// ****************************************************************
// field positions, reset values and limits
// ****************************************************************
`define SWPC_EXP_MSB 15
`define SWPC_EXP_LSB 11
`define SWPC_MAN_MSB 10
`define SWPC_GAIN_RESET 16'hAA66
`define SWPC_INTER_USED 16'h00FF
`define SWPC_PAGE1_OFFSET 4'h1
`define SWPC_BASE_KHZ 32'h00003E80
`define SWPC_MIN_KHZ 32'sh000000C8
`define SWPC_MAX_KHZ 32'sh00000532
`define SWPC_DIV_MIN 7'h0B
`define SWPC_DIV_MAX 7'h50
`define SWPC_STEP_TENTHS 12'h0E1

`endif

// ===== swpc_pkg.sv
package swpc_pkg;

  // start-up sequence: two strap sync cycles, one load, then run
  typedef enum logic [1:0] {
    SWPC_WAIT0 = 2'h0,
    SWPC_WAIT1 = 2'h1,
    SWPC_LOAD = 2'h3,
    SWPC_RUN = 2'h2
  } swpc_state_t;

endpackage : swpc_pkg

// ===== swpc_freq_if.sv
`timescale 1ns/10ps
interface swpc_freq_if (
  input wire logic clk,
  input wire logic rst
);
  logic [15:0] code;
  logic in_range;
  logic [6:0] divisor;

  modport conv (input clk, input rst, input code, output in_range,
    output divisor);
  modport user (input clk, input rst, output code, input in_range,
    input divisor);
endinterface : swpc_freq_if

// ===== swpc_freq_conv.sv
`timescale 1ns/10ps
`include "swpc_consts.svh"
module swpc_freq_conv (
  swpc_freq_if.conv fif
);
  // ****************************************************************
  // linear-11 decode
  // ****************************************************************
  function automatic logic signed [31:0] swpc_lin11(
    input logic [15:0] c
  );
    logic signed [4:0] e;
    logic signed [31:0] m;
    e = c[`SWPC_EXP_MSB:`SWPC_EXP_LSB];
    m = 32'(signed'(c[`SWPC_MAN_MSB:0]));
    if (e[4]) begin
      swpc_lin11 = m >>> 5'(-e);
    end else begin
      swpc_lin11 = m <<< 5'(e);
    end
  endfunction : swpc_lin11

  logic signed [31:0] khz;
  logic [31:0] khz_u;
  logic [31:0] quot;
  logic [6:0] n_raw;

  // fraction of a kHz is dropped; the divisor rounds to nearest
  assign khz = swpc_lin11(fif.code);
  assign fif.in_range = (khz >= `SWPC_MIN_KHZ) && (khz <= `SWPC_MAX_KHZ);
  assign khz_u = fif.in_range ? 32'(khz) : 32'h00000001;
  assign quot = (`SWPC_BASE_KHZ + (khz_u >> 1)) / khz_u;
  assign n_raw = (quot > 32'h0000007F) ? 7'h7F : quot[6:0];
  // clamp keeps the divisor legal even for an odd strap code
  assign fif.divisor = (n_raw < `SWPC_DIV_MIN) ? `SWPC_DIV_MIN :
    (n_raw > `SWPC_DIV_MAX) ? `SWPC_DIV_MAX : n_raw;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_lin11_zero_exp;
    @(posedge fif.clk) disable iff (fif.rst)
    (fif.code[15:11] == 5'h00) |-> (khz == 32'(signed'(fif.code[10:0])));
  endproperty
  a_lin11_zero_exp: assert property (p_lin11_zero_exp)
    else $error("linear-11 mantissa decode wrong");
endmodule : swpc_freq_conv

// ===== swpc_regs.sv
`timescale 1ns/10ps
`include "swpc_consts.svh"
module swpc_regs (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_PAGE,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [15:0] CMD_WDATA,
  input wire logic WRITE_PROTECT,
  input wire logic [15:0] STRAP_FREQ,
  input wire logic [6:0] STRAP_ADDR,
  input wire logic [1:0] SHARE_EN,
  input wire logic [3:0] SHARE_POS0,
  input wire logic [3:0] SHARE_POS1,
  output logic [15:0] CMD_RDATA,
  output logic CMD_ACK,
  output logic CMD_NACK,
  output logic CFG_READY,
  output logic [6:0] SW_DIVISOR,
  output logic [4:0] PHASE_GROUP0,
  output logic [4:0] PHASE_GROUP1,
  output logic [4:0] PHASE_POS0,
  output logic [4:0] PHASE_POS1,
  output logic [11:0] PHASE_TENTHS0,
  output logic [11:0] PHASE_TENTHS1,
  output logic [15:0] CAL_GAIN0,
  output logic [15:0] CAL_GAIN1
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] swpc_expand(input logic [3:0] v);
    swpc_expand = (v == 4'h0) ? 5'h10 : {1'b0, v};
  endfunction : swpc_expand

  function automatic logic [11:0] swpc_tenths(input logic [4:0] p);
    swpc_tenths = 12'(p) * `SWPC_STEP_TENTHS;
  endfunction : swpc_tenths

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [26:0] pin_meta_reg;
  logic [26:0] pin_sync_reg;
  logic wp_s;
  logic [15:0] strap_freq_s;
  logic [6:0] strap_addr_s;
  logic [1:0] share_s;
  logic [3:0] share_pos_s [2];
  logic [3:0] share_pos_meta0_reg;
  logic [3:0] share_pos_meta1_reg;
  logic [3:0] share_pos0_reg;
  logic [3:0] share_pos1_reg;

  // straps, protect and share pins arrive from other domains
  always_ff @(posedge CORE_CLK) begin
    pin_meta_reg <= {WRITE_PROTECT, STRAP_FREQ, STRAP_ADDR, SHARE_EN, 1'b0};
    pin_sync_reg <= pin_meta_reg;
    share_pos_meta0_reg <= SHARE_POS0;
    share_pos_meta1_reg <= SHARE_POS1;
    share_pos0_reg <= share_pos_meta0_reg;
    share_pos1_reg <= share_pos_meta1_reg;
  end

  assign wp_s = pin_sync_reg[26];
  assign strap_freq_s = pin_sync_reg[25:10];
  assign strap_addr_s = pin_sync_reg[9:3];
  assign share_s = pin_sync_reg[2:1];
  assign share_pos_s[0] = share_pos0_reg;
  assign share_pos_s[1] = share_pos1_reg;

  // ****************************************************************
  // start-up sequencer
  // ****************************************************************
  swpc_pkg::swpc_state_t state_reg;
  swpc_pkg::swpc_state_t state_next;

  // straps are caught only after two settled sync cycles
  always_comb begin
    case (state_reg)
      swpc_pkg::SWPC_WAIT0: state_next = swpc_pkg::SWPC_WAIT1;
      swpc_pkg::SWPC_WAIT1: state_next = swpc_pkg::SWPC_LOAD;
      swpc_pkg::SWPC_LOAD: state_next = swpc_pkg::SWPC_RUN;
      default: state_next = swpc_pkg::SWPC_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= swpc_pkg::SWPC_WAIT0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // frequency conversion
  // ****************************************************************
  logic loading;
  logic running;
  swpc_freq_if fif (.clk(CORE_CLK), .rst(RST));

  assign loading = (state_reg == swpc_pkg::SWPC_LOAD);
  assign running = (state_reg == swpc_pkg::SWPC_RUN);
  // one converter serves both the strap load and host writes
  assign fif.code = loading ? strap_freq_s : CMD_WDATA;

  swpc_freq_conv u_conv (.fif(fif));

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic hit_freq;
  logic hit_inter;
  logic hit_gain;
  logic hit_any;
  logic wr_ok;
  logic rd_ok;
  logic [15:0] rd_mux;
  logic [15:0] freq_reg;
  logic [15:0] inter_reg [2];
  logic [15:0] gain_reg [2];

  assign hit_freq = (CMD_CODE == `SWPC_CMD_FREQ);
  assign hit_inter = (CMD_CODE == `SWPC_CMD_INTER);
  assign hit_gain = (CMD_CODE == `SWPC_CMD_GAIN);
  assign hit_any = hit_freq || hit_inter || hit_gain;
  // protected writes and out-of-range frequencies are refused
  assign wr_ok = CMD_WR && running && hit_any && !wp_s &&
    (!hit_freq || fif.in_range);
  assign rd_ok = CMD_RD && !CMD_WR && running && hit_any;

  // read selection; unused interleave bits come back as zero
  always_comb begin
    if (hit_freq) begin
      rd_mux = freq_reg;
    end else if (hit_inter) begin
      rd_mux = inter_reg[CMD_PAGE] & `SWPC_INTER_USED;
    end else if (hit_gain) begin
      rd_mux = gain_reg[CMD_PAGE];
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // frequency is global; strap first, host write replaces it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      freq_reg <= 16'h0000;
      SW_DIVISOR <= `SWPC_DIV_MAX;
    end else if (loading || (wr_ok && hit_freq)) begin
      freq_reg <= fif.code;
      SW_DIVISOR <= fif.divisor;
    end
  end

  // paged registers; page 1 position defaults one step on
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      inter_reg[0] <= 16'h0000;
      inter_reg[1] <= 16'h0000;
      gain_reg[0] <= `SWPC_GAIN_RESET;
      gain_reg[1] <= `SWPC_GAIN_RESET;
    end else if (loading) begin
      inter_reg[0] <= {12'h000, strap_addr_s[3:0]};
      inter_reg[1] <= {12'h000, strap_addr_s[3:0] + `SWPC_PAGE1_OFFSET};
    end else if (wr_ok && hit_inter) begin
      inter_reg[CMD_PAGE] <= CMD_WDATA & `SWPC_INTER_USED;
    end else if (wr_ok && hit_gain) begin
      gain_reg[CMD_PAGE] <= CMD_WDATA;
    end
  end

  // answer one cycle after the request
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      CMD_ACK <= 1'b0;
      CMD_NACK <= 1'b0;
      CMD_RDATA <= 16'h0000;
      CFG_READY <= 1'b0;
    end else begin
      CMD_ACK <= wr_ok || rd_ok;
      CMD_NACK <= (CMD_WR && !wr_ok) || (CMD_RD && !CMD_WR && !rd_ok);
      CFG_READY <= running;
      if (rd_ok) begin
        CMD_RDATA <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // phase outputs
  // ****************************************************************
  logic [4:0] pos_next [2];
  logic [4:0] grp_next [2];

  // a sharing rail takes its position from the share link instead
  genvar g;
  for (g = 0; g < 2; g++) begin : g_page
    assign pos_next[g] = share_s[g] ? swpc_expand(share_pos_s[g]) :
      swpc_expand(inter_reg[g][3:0]);
    assign grp_next[g] = share_s[g] ? 5'h00 :
      swpc_expand(inter_reg[g][7:4]);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PHASE_POS0 <= 5'h00;
      PHASE_POS1 <= 5'h00;
      PHASE_GROUP0 <= 5'h00;
      PHASE_GROUP1 <= 5'h00;
      PHASE_TENTHS0 <= 12'h000;
      PHASE_TENTHS1 <= 12'h000;
      CAL_GAIN0 <= `SWPC_GAIN_RESET;
      CAL_GAIN1 <= `SWPC_GAIN_RESET;
    end else begin
      PHASE_POS0 <= pos_next[0];
      PHASE_POS1 <= pos_next[1];
      PHASE_GROUP0 <= grp_next[0];
      PHASE_GROUP1 <= grp_next[1];
      PHASE_TENTHS0 <= swpc_tenths(pos_next[0]);
      PHASE_TENTHS1 <= swpc_tenths(pos_next[1]);
      CAL_GAIN0 <= gain_reg[0];
      CAL_GAIN1 <= gain_reg[1];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  property p_div_range;
    CFG_READY |-> (SW_DIVISOR >= 7'h0B) && (SW_DIVISOR <= 7'h50);
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("divisor outside 11..80");

  property p_strap_load;
    loading |=> (freq_reg == $past(strap_freq_s));
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap frequency not loaded");

  property p_range_refused;
    (CMD_WR && hit_freq && running && !fif.in_range) |=>
      CMD_NACK && $stable(freq_reg) && $stable(SW_DIVISOR);
  endproperty
  a_range_refused: assert property (p_range_refused)
    else $error("out-of-range frequency accepted");

  property p_protect;
    (CMD_WR && wp_s && running) |=> CMD_NACK && !CMD_ACK &&
      $stable(gain_reg[0]) && $stable(inter_reg[0]) && $stable(freq_reg);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write changed a register");

  property p_inter_zero;
    (rd_ok && hit_inter) |=> (CMD_RDATA[15:8] == 8'h00);
  endproperty
  a_inter_zero: assert property (p_inter_zero)
    else $error("interleave upper byte not zero");

  property p_pos_sixteen;
    (!share_s[0] && inter_reg[0][3:0] == 4'h0) |=>
      (PHASE_POS0 == 5'h10) && (PHASE_TENTHS0 == 12'hE10);
  endproperty
  a_pos_sixteen: assert property (p_pos_sixteen)
    else $error("position zero not shown as sixteen");

  property p_grp_sixteen;
    (!share_s[1] && inter_reg[1][7:4] == 4'h0) |=> (PHASE_GROUP1 == 5'h10);
  endproperty
  a_grp_sixteen: assert property (p_grp_sixteen)
    else $error("group zero not shown as sixteen");

  property p_share;
    (share_s[0] && share_pos_s[0] == 4'h2) |=> (PHASE_POS0 == 5'h02);
  endproperty
  a_share: assert property (p_share)
    else $error("sharing rail used interleave position");

  property p_page_sep;
    (wr_ok && hit_inter && CMD_PAGE) |=> $stable(inter_reg[0]);
  endproperty
  a_page_sep: assert property (p_page_sep)
    else $error("page 1 write touched page 0");

  property p_gain_reset;
    $fell(RST) |-> (CAL_GAIN0 == 16'hAA66) && (CAL_GAIN1 == 16'hAA66);
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain reset value wrong");

  c_freq_write: cover property (wr_ok && hit_freq ##1 CMD_ACK);
  c_gain_read: cover property (rd_ok && hit_gain ##1 CMD_ACK);
  c_protected: cover property (CMD_WR && wp_s ##1 CMD_NACK);
  c_shared: cover property (share_s[1] && running);
endmodule : swpc_regs

// ===== swpc_host_model.sv
`timescale 1ns/10ps
`include "swpc_consts.svh"
// ****************************************************************
// bus host facing the command port
// ****************************************************************
module swpc_host_model (
  input wire logic clk,
  input wire logic cmd_ack,
  input wire logic cmd_nack,
  input wire logic [15:0] cmd_rdata,
  output logic [7:0] cmd_code,
  output logic cmd_page,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [15:0] cmd_wdata
);
  logic rail_on_reg = 1'b0; // rail never enabled, no sync clock here
  // idle bus at time zero
  initial begin
    cmd_code = 8'h00;
    cmd_page = 1'b0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // one pulse per request; the answer stands only in the next cycle
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic p, input logic [15:0] d, output logic [17:0] ans);
    @(negedge clk);
    if (wr && code == `SWPC_CMD_FREQ && rail_on_reg) begin
      ans = 18'h00000;
    end else begin
      cmd_code = code;
      cmd_page = p;
      cmd_wdata = d; // whole 16-bit word in one request
      cmd_wr = wr;
      cmd_rd = !wr;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      // inverted leftovers so a late sample cannot match by luck
      cmd_wdata = ~d;
      cmd_code = ~code;
      ans = {cmd_ack, cmd_nack, cmd_rdata};
    end
  endtask : xfer
endmodule : swpc_host_model

// ===== tb.sv
`timescale 1ns/10ps
`include "swpc_consts.svh"
module tb;
  logic core_clk, rst, wr, rd, page, wp, ack, nack, ready, ok, p;
  logic [7:0] code;
  logic [15:0] wdata, rdata, strap_freq, gain0, gain1, w, d, keep;
  logic [6:0] strap_addr, divisor, old;
  logic [1:0] share_en;
  logic [3:0] spos0, spos1;
  logic [4:0] grp0, grp1, pos0, pos1;
  logic [11:0] ten0, ten1;
  logic [17:0] ans;
  int num_errors = 0, n_tests = 0, cycles = 0, i, v;
  logic [15:0] corners [6] = '{16'h00C8, 16'h0A99, 16'h00C7, 16'h0A9A,
    16'h07FF, 16'hF9F4};

  swpc_regs swpc_regs_inst (.CORE_CLK(core_clk), .RST(rst),
    .CMD_CODE(code), .CMD_PAGE(page), .CMD_WR(wr), .CMD_RD(rd),
    .CMD_WDATA(wdata), .WRITE_PROTECT(wp), .STRAP_FREQ(strap_freq),
    .STRAP_ADDR(strap_addr), .SHARE_EN(share_en), .SHARE_POS0(spos0),
    .SHARE_POS1(spos1), .CMD_RDATA(rdata), .CMD_ACK(ack),
    .CMD_NACK(nack), .CFG_READY(ready), .SW_DIVISOR(divisor),
    .PHASE_GROUP0(grp0), .PHASE_GROUP1(grp1), .PHASE_POS0(pos0),
    .PHASE_POS1(pos1), .PHASE_TENTHS0(ten0), .PHASE_TENTHS1(ten1),
    .CAL_GAIN0(gain0), .CAL_GAIN1(gain1));
  swpc_host_model swpc_host_model_inst (.clk(core_clk), .cmd_ack(ack),
    .cmd_nack(nack), .cmd_rdata(rdata), .cmd_code(code),
    .cmd_page(page), .cmd_wr(wr), .cmd_rd(rd), .cmd_wdata(wdata));

  // ****************************************************************
  // expectations and checks
  // ****************************************************************
  // decoded word; fraction dropped, mantissa sign kept by arithmetic shift when e < 0
  function automatic int lin_val(input logic [15:0] x);
    int e, m;
    e = $signed(x[15:11]);
    m = $signed(x[10:0]);
    return (e >= 0) ? (m <<< e) : (m >>> -e);
  endfunction : lin_val
  // nearest divisor of the 16000 kHz base, clamped
  function automatic logic [15:0] exp_div(input int k);
    int n;
    n = (32000 + k) / (2 * k);
    n = (n < 11) ? 11 : ((n > 80) ? 80 : n);
    return n[15:0];
  endfunction : exp_div
  task automatic chk_val(input logic [15:0] got, input logic [15:0] e);
    n_tests++;
    if (got !== e) begin
      num_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, e);
    end
  endtask : chk_val
  task automatic chk_ans(input logic [1:0] got, input logic [1:0] e);
    n_tests++;
    if (got !== e) begin
      num_errors++;
      $display("ERROR %0t ack/nack %b expected %b", $time, got, e);
    end
  endtask : chk_ans
  task automatic op(input logic w1, input logic [7:0] c, input logic q,
    input logic [15:0] dd, input logic a);
    swpc_host_model_inst.xfer(w1, c, q, dd, ans);
    chk_ans(ans[17:16], a ? 2'h2 : 2'h1);
  endtask : op
  task automatic chk_phase(input logic q, input int g, input int s);
    chk_val({11'h000, q ? grp1 : grp0}, g[15:0]);
    chk_val({11'h000, q ? pos1 : pos0}, s[15:0]);
    chk_val({4'h0, q ? ten1 : ten0}, 16'(s * 225));
  endtask : chk_phase
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // clock, hang guard and main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // whole run needs under 1500 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'hA438));
    rst = 1'b1;
    wp = 1'b0;
    strap_freq = 16'h01F4;
    strap_addr = 7'h25;
    share_en = 2'h0;
    spos0 = 4'h0;
    spos1 = 4'h0;
    repeat (12) @(negedge core_clk);
    chk_val(gain0, `SWPC_GAIN_RESET);
    chk_val(gain1, `SWPC_GAIN_RESET);
    chk_val({15'h0000, ready}, 16'h0000);
    chk_val({9'h000, divisor}, 16'h0050);
    rst = 1'b0;
    op(1'b0, `SWPC_CMD_FREQ, 1'b0, 16'h0000, 1'b0);
    for (i = 0; i < 10 && ready !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    chk_val({15'h0000, ready}, 16'h0001);
    chk_val({9'h000, divisor}, exp_div(500));
    op(1'b0, `SWPC_CMD_FREQ, 1'b1, 16'h0000, 1'b1);
    chk_val(ans[15:0], 16'h01F4);
    op(1'b0, `SWPC_CMD_INTER, 1'b0, 16'h0000, 1'b1);
    chk_val(ans[15:0], 16'h0005);
    op(1'b0, `SWPC_CMD_INTER, 1'b1, 16'h0000, 1'b1);
    chk_val(ans[15:0], 16'h0006);
    chk_phase(1'b0, 16, 5);
    // frequency corners first, then random exponents and mantissas
    for (i = 0; i < 46; i++) begin
      w = corners[i % 6];
      if (i >= 6) begin
        w[15:11] = 5'($urandom_range(3, 0)) - 5'h02;
        w[10:0] = {1'b0, 10'($urandom)};
      end
      v = lin_val(w);
      ok = (v >= 200 && v <= 1330);
      old = divisor;
      p = 1'($urandom);
      op(1'b1, `SWPC_CMD_FREQ, p, w, ok);
      chk_val({9'h000, divisor}, ok ? exp_div(v) : {9'h000, old});
      if (ok) begin
        op(1'b0, `SWPC_CMD_FREQ, ~p, 16'h0000, 1'b1);
        chk_val(ans[15:0], w);
      end
    end
    for (i = 0; i < 10; i++) begin
      p = 1'($urandom);
      d = 16'($urandom);
      keep = p ? gain0 : gain1;
      op(1'b1, `SWPC_CMD_GAIN, p, d, 1'b1);
      @(negedge core_clk);
      chk_val(p ? gain1 : gain0, d);
      chk_val(p ? gain0 : gain1, keep);
      op(1'b0, `SWPC_CMD_GAIN, p, 16'h0000, 1'b1);
      chk_val(ans[15:0], d);
    end
    // every group and position, zero codes included on page 0
    for (i = 0; i < 16; i++) begin
      p = i[0] ^ i[1];
      d = {8'($urandom), i[3:0], 4'(15 - i)};
      op(1'b1, `SWPC_CMD_INTER, p, d, 1'b1);
      @(negedge core_clk);
      chk_phase(p, i == 0 ? 16 : i, i == 15 ? 16 : 15 - i);
      op(1'b0, `SWPC_CMD_INTER, p, 16'h0000, 1'b1);
      chk_val(ans[15:0], {8'h00, d[7:0]});
    end
    share_en = 2'h3;
    repeat (4) @(negedge core_clk);
    chk_phase(1'b0, 0, 16);
    chk_phase(1'b1, 0, 16);
    spos0 = 4'h2;
    repeat (4) @(negedge core_clk);
    chk_phase(1'b0, 0, 2);
    share_en = 2'h0;
    wp = 1'b1;
    repeat (3) @(negedge core_clk);
    keep = gain0;
    op(1'b1, `SWPC_CMD_GAIN, 1'b0, ~keep, 1'b0);
    chk_val(gain0, keep);
    op(1'b1, `SWPC_CMD_FREQ, 1'b0, 16'h00C8, 1'b0);
    op(1'b0, `SWPC_CMD_GAIN, 1'b0, 16'h0000, 1'b1);
    chk_val(ans[15:0], keep);
    wp = 1'b0;
    op(1'b0, 8'h39, 1'b0, 16'h0000, 1'b0);
    give_verdict();
  end
endmodule : tb
